// >>> logic/rf_ctrl_pkg.sv
package rf_ctrl_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_PAYLOAD  = 8'h04;
  localparam logic [7:0] OFS_LUT_SIZE = 8'h08;
  localparam logic [7:0] OFS_LUT_ADDR = 8'h0c;
  localparam logic [7:0] OFS_LUT_DATA = 8'h10;
  localparam logic [7:0] OFS_RX_BASE  = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_NV_CFG   = 8'h1c;
  localparam logic [7:0] OFS_RAND_ID  = 8'h20;
  // ****************************************
  // command register fields
  // ****************************************
  localparam logic [2:0] CMD_IDLE       = 3'h0;
  localparam logic [2:0] CMD_AUTOCOLL   = 3'h2;
  localparam logic [2:0] CMD_TRANSCEIVE = 3'h3;
  localparam int         CMD_SEND_BIT   = 3;
  localparam int         CMD_MODE_LSB   = 4;
  // ****************************************
  // adaptation table word layout
  // ****************************************
  localparam int MASK_LSB = 16;
  localparam int LVLP_LSB = 13;
  localparam int LVL_LSB  = 10;
  localparam int GAIN_LSB = 7;
  localparam int HPCF_LSB = 4;
  localparam int GEAR_LSB = 0;
  localparam int ADAPT_NIB_LSB = 4;
  // ****************************************
  // receiver tuning ranges and reset values
  // ****************************************
  localparam logic [3:0] MAX_2BIT   = 4'h3;
  localparam logic [3:0] MAX_4BIT   = 4'hf;
  localparam logic [15:0] RX_BASE_RST = 16'h0000;
  localparam logic [31:0] LFSR_SEED   = 32'h0000_0001;
  localparam logic [31:0] LFSR_TAPS   = 32'h8020_0003;
  // ****************************************
  // state machines
  // ****************************************
  typedef enum logic [1:0] {TRX_IDLE, TRX_WAIT_SEND, TRX_TX, TRX_RX} trx_state_t;
  typedef enum logic [2:0] {
    AC_OFF, AC_GEN_LOAD, AC_LISTEN, AC_TECH_LOAD, AC_WAIT_ACT, AC_STANDBY
  } ac_state_t;
  typedef enum logic [1:0] {AD_IDLE, AD_FETCH, AD_EVAL} ad_state_t;
endpackage

// >>> logic/adapt_table_mem.sv
`timescale 1ns/1ps
module adapt_table_mem #(
  parameter int AW = 5,
  parameter int DW = 32
) (
  input  wire logic          pclk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);
  // ****************************************
  // storage, registered read
  // ****************************************
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge pclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
    end
  end
endmodule

// >>> logic/rf_transceive_card_emulation_ctrl.sv
//
// Function
// - table word bits 31:16 are a one-hot protocol and rate mask
// - bits 15:13 give signed change, up to three, to p-channel threshold
// - bits 12:10 give signed change, up to three, to receive threshold
// - bits 9:7 change gain, bits 6:4 change high-pass corner, sign-magnitude
// - bits 3:0 name the gear where the entry applies
// - zero adaptation nibble of size entry disables receiver adaptation
// - on gear switch find matching entry and update receiver settings
// - one transceive command sends then receives without host help
// - writing transceive code to command field starts the machine
// - transceive machine never ends by itself
// - writing idle code to command field stops transceive
// - send trigger from control bit or payload write instruction
// - auto-activation runs card and target activation without host
// - configuration zero exits whenever external field is absent
// - configuration one exits on activation, enters standby when field off
// - configuration two exits on activation, stays awake when field off
// - auto-activation start loads general target-mode settings
// - detected technology triggers a second, matching settings load
// - random identifier option makes fresh identifier after each field loss
// - active target switches own field on after initiator field goes off (here only in auto-activation; one cycle in configuration zero)
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
module rf_transceive_card_emulation_ctrl #(
  parameter int LUT_AW = 5
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  power_gear,
  input  wire logic [3:0]  proto_rate,
  input  wire logic        ext_field,
  input  wire logic        tech_detected,
  input  wire logic [1:0]  tech_kind,
  input  wire logic        tech_activated,
  input  wire logic        active_target,
  input  wire logic        tx_done,
  input  wire logic        rx_done,
  output logic             tx_start,
  output logic             rx_enable,
  output logic             rf_settings_load,
  output logic             rf_settings_general,
  output logic [1:0]       rf_settings_tech,
  output logic             standby,
  output logic             own_field_on,
  output logic [1:0]       rx_gain,
  output logic [1:0]       rx_highpass_corner,
  output logic [3:0]       rx_threshold,
  output logic [3:0]       rx_threshold_p,
  output logic [31:0]      random_id
);
  // ****************************************
  // apb decode
  // ****************************************
  wire logic setup   = psel & ~penable;
  wire logic wr_fire = psel & penable & pready & pwrite;
  wire logic hit_cmd = paddr == rf_ctrl_pkg::OFS_CMD;
  wire logic hit_pay = paddr == rf_ctrl_pkg::OFS_PAYLOAD;
  wire logic hit_siz = paddr == rf_ctrl_pkg::OFS_LUT_SIZE;
  wire logic hit_lad = paddr == rf_ctrl_pkg::OFS_LUT_ADDR;
  wire logic hit_ldt = paddr == rf_ctrl_pkg::OFS_LUT_DATA;
  wire logic hit_rxb = paddr == rf_ctrl_pkg::OFS_RX_BASE;
  wire logic hit_sts = paddr == rf_ctrl_pkg::OFS_STATUS;
  wire logic hit_nvc = paddr == rf_ctrl_pkg::OFS_NV_CFG;
  wire logic hit_rid = paddr == rf_ctrl_pkg::OFS_RAND_ID;
  wire logic mapped  = hit_cmd | hit_pay | hit_siz | hit_lad | hit_ldt | hit_rxb
                     | hit_sts | hit_nvc | hit_rid;

  logic [2:0]        cmd_q;
  logic [1:0]        ac_mode_q;
  logic [31:0]       payload_q;
  logic [7:0]        lut_size_q;
  logic [LUT_AW-1:0] lut_addr_q;
  logic              rand_opt_q;
  logic              send_pend_q;
  logic              ext_field_q;
  logic [3:0]        gear_q;
  logic [31:0]       lfsr_q;
  rf_ctrl_pkg::trx_state_t trx_q;
  rf_ctrl_pkg::ac_state_t  ac_q;
  rf_ctrl_pkg::ad_state_t  ad_q;

  // send trigger: control bit or payload write instruction
  wire logic send_evt = wr_fire & ((hit_cmd & pwdata[rf_ctrl_pkg::CMD_SEND_BIT]) | hit_pay);
  wire logic cmd_wr   = wr_fire & hit_cmd;
  wire logic lut_we   = wr_fire & hit_ldt;
  wire logic field_fall = ext_field_q & ~ext_field;
  wire logic ac_run   = ac_q != rf_ctrl_pkg::AC_OFF;

  wire logic [31:0] status_w = {16'h0000, 4'h0, gear_q, 1'b0, ac_q, own_field_on,
                                standby, trx_q};
  wire logic [31:0] rd_w =
    hit_cmd ? {26'h0, ac_mode_q, 1'b0, cmd_q} :
    hit_pay ? payload_q :
    hit_siz ? {24'h0, lut_size_q} :
    hit_lad ? {{(32-LUT_AW){1'b0}}, lut_addr_q} :
    hit_rxb ? {16'h0, rx_threshold_p, rx_threshold, rx_gain, rx_highpass_corner, 4'h0} :
    hit_sts ? status_w :
    hit_nvc ? {31'h0, rand_opt_q} :
    hit_rid ? random_id : 32'h0000_0000;

  // no wait state: answer is prepared in the setup cycle so that
  // prdata and pready both leave flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? rd_w : 32'h0000_0000;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  wire logic ac_exit;
  wire logic [2:0] cmd_new = pwdata[2:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q      <= rf_ctrl_pkg::CMD_IDLE;
      ac_mode_q  <= 2'h0;
      payload_q  <= 32'h0000_0000;
      lut_size_q <= 8'h00;
      lut_addr_q <= '0;
      rand_opt_q <= 1'b0;
    end else if (ce) begin
      if (cmd_wr) begin
        cmd_q     <= cmd_new;
        ac_mode_q <= pwdata[rf_ctrl_pkg::CMD_MODE_LSB +: 2];
      end else if (ac_exit) begin
        cmd_q <= rf_ctrl_pkg::CMD_IDLE;
      end
      if (wr_fire & hit_pay) payload_q <= pwdata;
      if (wr_fire & hit_siz) lut_size_q <= pwdata[7:0];
      if (wr_fire & hit_nvc) rand_opt_q <= pwdata[0];
      if (wr_fire & hit_lad) begin
        lut_addr_q <= pwdata[LUT_AW-1:0];
      end else if (lut_we) begin
        lut_addr_q <= lut_addr_q + 1'b1;
      end
    end
  end

  // ****************************************
  // transceive state machine
  // ****************************************
  wire logic trx_stop  = cmd_wr & (cmd_new == rf_ctrl_pkg::CMD_IDLE);
  wire logic trx_begin = cmd_wr & (cmd_new == rf_ctrl_pkg::CMD_TRANSCEIVE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trx_q       <= rf_ctrl_pkg::TRX_IDLE;
      send_pend_q <= 1'b0;
      tx_start    <= 1'b0;
      rx_enable   <= 1'b0;
    end else if (ce) begin
      tx_start <= 1'b0;
      // a new trigger wins over the consume in the same cycle
      if (send_evt) begin
        send_pend_q <= 1'b1;
      end else if (trx_q == rf_ctrl_pkg::TRX_WAIT_SEND) begin
        send_pend_q <= 1'b0;
      end
      if (trx_stop) begin
        trx_q       <= rf_ctrl_pkg::TRX_IDLE;
        send_pend_q <= send_evt;
        rx_enable   <= 1'b0;
      end else begin
        case (trx_q)
          rf_ctrl_pkg::TRX_IDLE: begin
            if (trx_begin) trx_q <= rf_ctrl_pkg::TRX_WAIT_SEND;
          end
          rf_ctrl_pkg::TRX_WAIT_SEND: begin
            if (send_pend_q) begin
              tx_start <= 1'b1;
              trx_q    <= rf_ctrl_pkg::TRX_TX;
            end
          end
          rf_ctrl_pkg::TRX_TX: begin
            if (tx_done) begin
              rx_enable <= 1'b1;
              trx_q     <= rf_ctrl_pkg::TRX_RX;
            end
          end
          default: begin
            // back to waiting, never to idle on its own
            if (rx_done) begin
              rx_enable <= 1'b0;
              trx_q     <= rf_ctrl_pkg::TRX_WAIT_SEND;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // auto-activation state machine
  // ****************************************
  wire logic ac_begin  = cmd_wr & (cmd_new == rf_ctrl_pkg::CMD_AUTOCOLL);
  wire logic ac_stop   = cmd_wr & (cmd_new != rf_ctrl_pkg::CMD_AUTOCOLL);
  wire logic mode0     = ac_mode_q == 2'h0;
  wire logic mode1     = ac_mode_q == 2'h1;
  wire logic no_field  = ~ext_field;
  wire logic act_exit  = ~mode0 & tech_activated
                       & (ac_q == rf_ctrl_pkg::AC_WAIT_ACT);
  wire logic off_exit  = mode0 & no_field & ac_run;
  assign ac_exit = (act_exit | off_exit) & ~cmd_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_q                <= rf_ctrl_pkg::AC_OFF;
      rf_settings_load    <= 1'b0;
      rf_settings_general <= 1'b0;
      rf_settings_tech    <= 2'h0;
      standby             <= 1'b0;
    end else if (ce) begin
      rf_settings_load <= 1'b0;
      if (ac_stop | ac_exit) begin
        ac_q    <= rf_ctrl_pkg::AC_OFF;
        standby <= 1'b0;
      end else if (ac_begin) begin
        ac_q <= rf_ctrl_pkg::AC_GEN_LOAD;
      end else begin
        case (ac_q)
          rf_ctrl_pkg::AC_GEN_LOAD: begin
            rf_settings_load    <= 1'b1;
            rf_settings_general <= 1'b1;
            ac_q                <= rf_ctrl_pkg::AC_LISTEN;
          end
          rf_ctrl_pkg::AC_LISTEN, rf_ctrl_pkg::AC_WAIT_ACT: begin
            if (no_field) begin
              // mode two stays awake and simply restarts listening
              if (mode1) begin
                standby <= 1'b1;
                ac_q    <= rf_ctrl_pkg::AC_STANDBY;
              end else begin
                ac_q <= rf_ctrl_pkg::AC_LISTEN;
              end
            end else if (tech_detected & (ac_q == rf_ctrl_pkg::AC_LISTEN)) begin
              rf_settings_tech <= tech_kind;
              ac_q             <= rf_ctrl_pkg::AC_TECH_LOAD;
            end
          end
          rf_ctrl_pkg::AC_TECH_LOAD: begin
            rf_settings_load    <= 1'b1;
            rf_settings_general <= 1'b0;
            ac_q                <= rf_ctrl_pkg::AC_WAIT_ACT;
          end
          rf_ctrl_pkg::AC_STANDBY: begin
            if (ext_field) begin
              standby <= 1'b0;
              ac_q    <= rf_ctrl_pkg::AC_LISTEN;
            end
          end
          default: ac_q <= rf_ctrl_pkg::AC_OFF;
        endcase
      end
    end
  end

  // ****************************************
  // field edge, random identifier, own field
  // ****************************************
  wire logic [31:0] lfsr_next = lfsr_q[0] ? ((lfsr_q >> 1) ^ rf_ctrl_pkg::LFSR_TAPS)
                                          : (lfsr_q >> 1);

  // the generator runs free so the identifier depends on when the field drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_field_q  <= 1'b0;
      lfsr_q       <= rf_ctrl_pkg::LFSR_SEED;
      random_id    <= 32'h0000_0000;
      own_field_on <= 1'b0;
    end else if (ce) begin
      ext_field_q <= ext_field;
      lfsr_q      <= lfsr_next;
      if (field_fall & rand_opt_q) random_id <= lfsr_q;
      if (~ac_run | ext_field) begin
        own_field_on <= 1'b0;
      end else if (field_fall & active_target) begin
        own_field_on <= 1'b1;
      end
    end
  end

  // ****************************************
  // receiver adaptation
  // ****************************************
  logic [31:0]       lut_rd;
  logic [3:0]        idx_q;
  logic [LUT_AW-1:0] rd_addr;
  wire logic [3:0] adapt_n  = lut_size_q[rf_ctrl_pkg::ADAPT_NIB_LSB +: 4];
  wire logic [3:0] shape_n  = lut_size_q[3:0];
  wire logic       gear_sw  = power_gear != gear_q;
  wire logic [15:0] entry_mask = lut_rd[rf_ctrl_pkg::MASK_LSB +: 16];
  wire logic [3:0] entry_gear = lut_rd[rf_ctrl_pkg::GEAR_LSB +: 4];
  wire logic       entry_hit  = entry_mask[proto_rate] & (entry_gear == gear_q);
  wire logic       last_idx   = (idx_q + 4'h1) >= adapt_n;
  assign rd_addr = LUT_AW'(shape_n) + LUT_AW'(idx_q);

  adapt_table_mem #(
    .AW (LUT_AW),
    .DW (32)
  ) u_table (
    .pclk    (pclk),
    .ce      (ce),
    .we      (lut_we),
    .waddr   (lut_addr_q),
    .wdata   (pwdata),
    .raddr   (rd_addr),
    .rdata_q (lut_rd)
  );

  // sign-magnitude delta, clamped to [0, maxv]
  function automatic logic [3:0] rel_apply(input logic [3:0] cur, input logic [2:0] dlt,
                                           input logic [3:0] maxv);
    logic [4:0] sum;
    sum = 5'h00;
    if (dlt[2]) begin
      rel_apply = (cur > {2'h0, dlt[1:0]}) ? cur - {2'h0, dlt[1:0]} : 4'h0;
    end else begin
      sum       = {1'b0, cur} + {3'h0, dlt[1:0]};
      rel_apply = (sum > {1'b0, maxv}) ? maxv : sum[3:0];
    end
  endfunction

  wire logic [3:0] nxt_lvlp = rel_apply(rx_threshold_p, lut_rd[rf_ctrl_pkg::LVLP_LSB +: 3],
                                        rf_ctrl_pkg::MAX_4BIT);
  wire logic [3:0] nxt_lvl  = rel_apply(rx_threshold, lut_rd[rf_ctrl_pkg::LVL_LSB +: 3],
                                        rf_ctrl_pkg::MAX_4BIT);
  wire logic [3:0] nxt_gain = rel_apply({2'h0, rx_gain}, lut_rd[rf_ctrl_pkg::GAIN_LSB +: 3],
                                        rf_ctrl_pkg::MAX_2BIT);
  wire logic [3:0] nxt_hpcf = rel_apply({2'h0, rx_highpass_corner},
                                        lut_rd[rf_ctrl_pkg::HPCF_LSB +: 3],
                                        rf_ctrl_pkg::MAX_2BIT);

  // a software base write reloads the settings, later gear switches
  // accumulate on top of them; the first matching entry wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ad_q               <= rf_ctrl_pkg::AD_IDLE;
      idx_q              <= 4'h0;
      gear_q             <= 4'h0;
      rx_gain            <= rf_ctrl_pkg::RX_BASE_RST[7:6];
      rx_highpass_corner <= rf_ctrl_pkg::RX_BASE_RST[5:4];
      rx_threshold       <= rf_ctrl_pkg::RX_BASE_RST[11:8];
      rx_threshold_p     <= rf_ctrl_pkg::RX_BASE_RST[15:12];
    end else if (ce) begin
      if (wr_fire & hit_rxb) begin
        rx_highpass_corner <= pwdata[5:4];
        rx_gain            <= pwdata[7:6];
        rx_threshold       <= pwdata[11:8];
        rx_threshold_p     <= pwdata[15:12];
        ad_q               <= rf_ctrl_pkg::AD_IDLE;
      end else begin
        case (ad_q)
          rf_ctrl_pkg::AD_IDLE: begin
            if (gear_sw) begin
              gear_q <= power_gear;
              idx_q  <= 4'h0;
              if (adapt_n != 4'h0) ad_q <= rf_ctrl_pkg::AD_FETCH;
            end
          end
          rf_ctrl_pkg::AD_FETCH: ad_q <= rf_ctrl_pkg::AD_EVAL;
          default: begin
            if (entry_hit) begin
              rx_threshold_p     <= nxt_lvlp;
              rx_threshold       <= nxt_lvl;
              rx_gain            <= nxt_gain[1:0];
              rx_highpass_corner <= nxt_hpcf[1:0];
              ad_q               <= rf_ctrl_pkg::AD_IDLE;
            end else if (last_idx) begin
              ad_q <= rf_ctrl_pkg::AD_IDLE;
            end else begin
              idx_q <= idx_q + 4'h1;
              ad_q  <= rf_ctrl_pkg::AD_FETCH;
            end
          end
        endcase
      end
    end
  end
endmodule

// >>> dv/rf_ctrl_checker.sv
`timescale 1ns/1ps
// ****************************************
// port checks of the rf control block
// ****************************************
module rf_ctrl_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_field,
  input wire logic        active_target,
  input wire logic        tx_start,
  input wire logic        tx_done,
  input wire logic        rx_enable,
  input wire logic        rx_done,
  input wire logic        rf_settings_load,
  input wire logic        rf_settings_general,
  input wire logic        standby,
  input wire logic        own_field_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire cmd_wr = psel && penable && pready && pwrite && paddr == rf_ctrl_pkg::OFS_CMD;
  wire ac_go  = cmd_wr && pwdata[2:0] == rf_ctrl_pkg::CMD_AUTOCOLL;
  wire idle_w = cmd_wr && pwdata[2:0] == rf_ctrl_pkg::CMD_IDLE;
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no access answer after setup");
  a_err_unmapped: assert property (pready && paddr > 8'h20 |-> pslverr)
    else $error("unmapped access not refused");
  a_gen_load: assert property (ac_go |-> ##[1:3] rf_settings_load && rf_settings_general)
    else $error("no general settings load after start");
  a_load_pulse: assert property (rf_settings_load |=> !rf_settings_load)
    else $error("settings load longer than one cycle");
  a_tx_pulse: assert property (tx_start |=> !tx_start)
    else $error("send start longer than one cycle");
  a_rx_after_tx: assert property ($rose(rx_enable) |-> $past(tx_done))
    else $error("reception began without end of send");
  a_rx_ends: assert property (rx_enable && rx_done |=> !rx_enable)
    else $error("reception kept after its end");
  a_idle_stops: assert property (idle_w |-> ##[1:2] !rx_enable)
    else $error("idle command did not stop transceive");
  a_standby_off: assert property ($rose(standby) |-> !$past(ext_field))
    else $error("standby entered with field present");
  a_own_field: assert property ($rose(own_field_on) |-> active_target)
    else $error("own field switched on outside active target");
endmodule
bind rf_transceive_card_emulation_ctrl rf_ctrl_checker chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .ext_field, .active_target, .tx_start, .tx_done,
  .rx_enable, .rx_done, .rf_settings_load, .rf_settings_general, .standby, .own_field_on);

// >>> dv/rf_reader_model.sv
`timescale 1ns/1ps
// ****************************************
// external reader and rf engine model
// ****************************************
module rf_reader_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_start,
  input  wire logic       rx_enable,
  input  wire logic       field_req,
  input  wire logic       detect_req,
  input  wire logic       act_req,
  input  wire logic [1:0] kind_req,
  input  wire logic       rx_mute,
  output logic            ext_field,
  output logic            tech_detected,
  output logic [1:0]      tech_kind,
  output logic            tech_activated,
  output logic            tx_done,
  output logic            rx_done
);
  logic [3:0] tcnt_q;
  logic [3:0] rcnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ext_field, tech_detected, tech_kind, tech_activated, tx_done, rx_done} <= '0;
      tcnt_q <= 4'h0;
      rcnt_q <= 4'h0;
    end else begin
      ext_field <= field_req;
      tech_detected <= detect_req;
      tech_activated <= act_req;
      // outside a detection the code flips so a stale sample never matches
      tech_kind <= detect_req ? kind_req : ~tech_kind;
      tcnt_q <= tx_start ? 4'h3 : (tcnt_q != 4'h0 ? tcnt_q - 4'h1 : tcnt_q);
      tx_done <= tcnt_q == 4'h1;
      rcnt_q <= rx_enable ? rcnt_q + 4'h1 : 4'h0;
      // muted reader never answers: only the host can end the command
      rx_done <= rx_enable && !rx_mute && rcnt_q == 4'h5 && !rx_done;
    end
  end
endmodule

// >>> dv/rf_transceive_card_emulation_ctrl_bench.sv
`timescale 1ns/1ps
// ****************************************
// bench of the rf control block
// ****************************************
module rf_transceive_card_emulation_ctrl_bench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  power_gear = 4'h0, proto_rate = 4'h3;
  logic        active_target = 1'b0, field = 1'b0, det = 1'b0, act = 1'b0, mute = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [31:0] prdata, random_id, rdat, r0;
  logic        pready, pslverr, serr, ext_field, tech_detected, tech_activated;
  logic        tx_done, rx_done, tx_start, rx_enable, rf_settings_load;
  logic        rf_settings_general, standby, own_field_on;
  logic [1:0]  tech_kind, rf_settings_tech, rx_gain, rx_highpass_corner;
  logic [3:0]  rx_threshold, rx_threshold_p;
  int          errors = 0, checked = 0;
  always #25 pclk = ~pclk;
  rf_transceive_card_emulation_ctrl dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .power_gear, .proto_rate, .ext_field,
    .tech_detected, .tech_kind, .tech_activated, .active_target, .tx_done, .rx_done, .tx_start,
    .rx_enable, .rf_settings_load, .rf_settings_general, .rf_settings_tech, .standby,
    .own_field_on, .rx_gain, .rx_highpass_corner, .rx_threshold, .rx_threshold_p, .random_id);
  rf_reader_model rdr (.pclk, .presetn, .tx_start, .rx_enable, .field_req(field),
    .detect_req(det), .act_req(act), .kind_req(kind), .rx_mute(mute), .ext_field,
    .tech_detected, .tech_kind, .tech_activated, .tx_done, .rx_done);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int k, input logic v);
    logic [4:0] s;
    for (int i = 0; i < 200; i++) begin
      s = {own_field_on, standby, rf_settings_load, rx_enable, tx_start};
      if (s[k] === v) break;
      @(posedge pclk);
    end
    chk("wait", 32'(s[k]), 32'(v));
  endtask
  task automatic tech(input logic [1:0] k);
    @(posedge pclk);
    det <= 1'b1;
    kind <= k;
    @(posedge pclk);
    det <= 1'b0;
    wt(2, 1'b1);
    chk("general", 32'(rf_settings_general), 32'h0);
    chk("tech", 32'(rf_settings_tech), 32'(k));
    act <= 1'b1;
    @(posedge pclk);
    act <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(rf_ctrl_pkg::OFS_CMD);
    chk("exit", 32'(rdat[2:0]), 32'h0);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(rf_ctrl_pkg::OFS_RX_BASE);
    chk("rxb rst", rdat, 32'h0);
    rd(8'h3c);
    chk("slverr", 32'(serr), 32'h1);
    chk("unmapped", rdat, 32'h0);
    wr(rf_ctrl_pkg::OFS_RX_BASE, 32'he460);
    wr(rf_ctrl_pkg::OFS_LUT_SIZE, 32'h01);
    wr(rf_ctrl_pkg::OFS_LUT_ADDR, 32'h1);
    wr(rf_ctrl_pkg::OFS_LUT_DATA, 32'h0008_7f15);
    power_gear <= 4'h5;
    repeat (12) @(posedge pclk);
    rd(rf_ctrl_pkg::OFS_RX_BASE);
    chk("off", rdat, 32'he460);
    power_gear <= 4'h0;
    repeat (12) @(posedge pclk);
    wr(rf_ctrl_pkg::OFS_LUT_SIZE, 32'h11);
    power_gear <= 4'h5;
    repeat (12) @(posedge pclk);
    chk("tune", 32'({rx_threshold_p, rx_threshold, rx_gain, rx_highpass_corner}), 32'hf13);
    rd(rf_ctrl_pkg::OFS_RX_BASE);
    chk("adapt", rdat, 32'hf130);
    proto_rate <= 4'h2;
    power_gear <= 4'h0;
    repeat (12) @(posedge pclk);
    power_gear <= 4'h5;
    repeat (12) @(posedge pclk);
    rd(rf_ctrl_pkg::OFS_RX_BASE);
    chk("mask", rdat, 32'hf130);
    wr(rf_ctrl_pkg::OFS_CMD, 32'h3);
    rd(rf_ctrl_pkg::OFS_STATUS);
    chk("trx", 32'(rdat[1:0]), 32'h1);
    wr(rf_ctrl_pkg::OFS_CMD, 32'hb);
    wt(0, 1'b1);
    wt(1, 1'b1);
    wt(1, 1'b0);
    rd(rf_ctrl_pkg::OFS_STATUS);
    chk("trx", 32'(rdat[1:0]), 32'h1);
    mute <= 1'b1;
    wr(rf_ctrl_pkg::OFS_PAYLOAD, 32'h5a);
    wt(0, 1'b1);
    wt(1, 1'b1);
    wr(rf_ctrl_pkg::OFS_CMD, 32'h0);
    repeat (3) @(posedge pclk);
    chk("rx", 32'(rx_enable), 32'h0);
    rd(rf_ctrl_pkg::OFS_STATUS);
    chk("trx", 32'(rdat[1:0]), 32'h0);
    field <= 1'b1;
    wr(rf_ctrl_pkg::OFS_CMD, 32'h12);
    wt(2, 1'b1);
    chk("general", 32'(rf_settings_general), 32'h1);
    field <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("standby", 32'(standby), 32'h1);
    field <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("standby", 32'(standby), 32'h0);
    tech(2'h2);
    wr(rf_ctrl_pkg::OFS_NV_CFG, 32'h1);
    rd(rf_ctrl_pkg::OFS_RAND_ID);
    r0 = rdat;
    active_target <= 1'b1;
    wr(rf_ctrl_pkg::OFS_CMD, 32'h22);
    wt(2, 1'b1);
    field <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("standby", 32'(standby), 32'h0);
    chk("own field", 32'(own_field_on), 32'h1);
    rd(rf_ctrl_pkg::OFS_RAND_ID);
    chk("new id", 32'(rdat !== r0), 32'h1);
    r0 = rdat;
    field <= 1'b1;
    active_target <= 1'b0;
    repeat (6) @(posedge pclk);
    tech(2'h1);
    wr(rf_ctrl_pkg::OFS_CMD, 32'h2);
    wt(2, 1'b1);
    field <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(rf_ctrl_pkg::OFS_CMD);
    chk("exit", 32'(rdat[2:0]), 32'h0);
    rd(rf_ctrl_pkg::OFS_RAND_ID);
    chk("id again", 32'(rdat !== r0), 32'h1);
    summarize();
  end
endmodule
